/* hdl/sct_map.vh */
`ifndef SCT_MAP_VH
`define SCT_MAP_VH
// Register indices on the plain register port
`define SCT_REG_BAUD 3'h0
`define SCT_REG_CTRL_ONE 3'h1
`define SCT_REG_CTRL_TWO 3'h2
`define SCT_REG_STAT_ONE 3'h3
`define SCT_REG_CTRL_THREE 3'h4
`define SCT_REG_DATA 3'h5
`define SCT_REG_NINTH 3'h6
// control_one_register fields
`define SCT_C1_NINE 0
`define SCT_C1_LBRK 1
// control_two_register fields
`define SCT_C2_RXON 2
`define SCT_C2_TXON 3
`define SCT_C2_BRK 0
// control_three_register fields
`define SCT_C3_TX_POLARITY_INVERT 4
`define SCT_C3_RX_POLARITY_INVERT 5
// status_one_register fields
`define SCT_S1_TX_BUFFER_EMPTY_FLAG 7
`define SCT_S1_TC 6
`define SCT_S1_RX_BUFFER_FULL_FLAG 5
`define SCT_S1_OR 3
`define SCT_S1_FE 1
// ninth-bit register fields
`define SCT_N_R8 7
`define SCT_N_T8 6
// Reset values
`define SCT_BAUD_RST 13'h0_004
`define SCT_BYTE_RST 8'h0_0
// Oversampling
`define SCT_RT_LAST 4'hf
`define SCT_RT_START_CHK 4'h6
`define SCT_RT_S1 4'h7
`define SCT_RT_S2 4'h8
`define SCT_RT_S3 4'h9
// Frame lengths in bit times, counting start and stop
`define SCT_LEN_8 4'ha
`define SCT_LEN_9 4'hb
`define SCT_LEN_BRK_LONG 4'hd
`define SCT_LEN_BRK_LONG9 4'he
`endif

/* hdl/sct_baud_gen.v */
`include "sct_map.vh"
// Divides the bus clock into a 16x bit-rate enable pulse shared by both directions
module sct_baud_gen (
   input wire sys_clk_in,
   input wire rstn_in,
   input wire [12:0] divisor_in,
   output reg tick16_out
);
   reg [12:0] cnt_r;
   always @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         cnt_r <= 13'h0_000;
         tick16_out <= 1'b0;
      end else if (divisor_in == 13'h0_000) begin
         // A zero divisor stops the generator
         cnt_r <= 13'h0_000;
         tick16_out <= 1'b0;
      end else if (cnt_r >= divisor_in - 13'h0_001) begin
         cnt_r <= 13'h0_000;
         tick16_out <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 13'h0_001;
         tick16_out <= 1'b0;
      end
   end
endmodule // sct_baud_gen

/* hdl/sct_core.v */
// Implementation choices: strobed register access and the address map.
`include "sct_map.vh"
// Notes on behaviour
// - Data address reads the receive buffer, writes the transmit buffer; both clear flags.
// - Transmitter and receiver run independently from one shared baud generator.
// - Baud generator counts the bus clock.
// - Receiver re-aligns bit timing on every falling edge within a character.
// - Transmit line idles high after reset; tx polarity invert flips it.
// - Enabling transmit sends one idle frame, then waits for buffer data.
// - Transmit frame is 10 bits, or 11 with nine-bit mode.
// - Free shifter loads waiting buffer on a baud tick; buffer-empty flag sets.
// - Nothing waiting after stop bit: set tx complete, idle high.
// - Disabling transmit releases the pin only after queued activity finishes.
// - Writing break bit one then zero queues one break frame.
// - Break bit still one when break loads queues another break.
// - Break is all zeros, 10, 11, 13 or 14 bit times long.
// - Transmitter keeps the pin through a quick off-on toggle.
// - Receiver works only when enabled; rx polarity invert flips input.
// - Frame is start zero, 8 or 9 data bits LSB first, stop one.
// - Completed character goes to a non-full buffer and sets buffer-full flag.
// - Character arriving while buffer full sets overrun and is dropped.
// - Buffer-full flag clears only by a two-access sequence, not by writes.
// - Sequence is status read with flag set, then data read.
// - Sixteen samples per bit; majority of slots eight, nine and ten.
module sct_core (
   input wire sys_clk_in,
   input wire rstn_in,
   input wire [2:0] addr_in,
   input wire [7:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   input wire rxd_in,
   output reg [7:0] rdata_out,
   output reg txd_out,
   output reg txd_oe_n_out
);
   localparam TX_IDLE = 2'b00;
   localparam TX_SHIFT = 2'b01;
   localparam RX_IDLE = 2'b00;
   localparam RX_START = 2'b01;
   localparam RX_DATA = 2'b10;

   reg [12:0] baud_r;
   reg nine_r, lbrk_r, rxon_r, txon_r, brk_r, tx_polarity_invert_r, rx_polarity_invert_r, t8_r, r8_r;
   reg [7:0] txbuf_r, rxbuf_r;
   reg tx_buffer_empty_flag_r, tc_r, rx_buffer_full_flag_r, or_r, fe_r;
   reg tx_buffer_empty_flag_seen_r, rx_buffer_full_flag_seen_r;
   reg idle_q_r, brk_q_r, txact_r;
   wire tick16;

   // Frame length in bit times for data or break
   function [3:0] frame_len;
      input nine;
      input brk;
      input lng;
      begin
         if (brk && lng)
            frame_len = nine ? `SCT_LEN_BRK_LONG9 : `SCT_LEN_BRK_LONG;
         else
            frame_len = nine ? `SCT_LEN_9 : `SCT_LEN_8;
      end
   endfunction

   function is_acc;
      input strobe;
      input [2:0] a;
      input [2:0] reg_idx;
      begin
         is_acc = strobe && (a == reg_idx);
      end
   endfunction

   wire data_rd = is_acc(rd_in, addr_in, `SCT_REG_DATA);
   wire data_wr = is_acc(wr_in, addr_in, `SCT_REG_DATA);
   wire stat_rd = is_acc(rd_in, addr_in, `SCT_REG_STAT_ONE);
   wire c2_wr = is_acc(wr_in, addr_in, `SCT_REG_CTRL_TWO);

   sct_baud_gen u_baud (
      .sys_clk_in(sys_clk_in),
      .rstn_in(rstn_in),
      .divisor_in(baud_r),
      .tick16_out(tick16)
   );

   // Transmitter
   reg [1:0] tx_st_r;
   reg [3:0] tx_sub_r;
   reg [3:0] tx_bits_r;
   reg [10:0] tx_sh_r;
   reg tx_brk_frame_r;
   wire tx_bit_tick = tick16 && (tx_sub_r == `SCT_RT_LAST);
   wire c2_txon_new = wdata_in[`SCT_C2_TXON];
   wire c2_brk_new = wdata_in[`SCT_C2_BRK];
   wire tx_done = (tx_st_r == TX_SHIFT) && tx_bit_tick && (tx_bits_r == 4'h1);
   // A load slot is the last bit edge of a frame, or any bit edge while idle but active
   wire tx_slot = tx_bit_tick && ((tx_st_r == TX_IDLE && txact_r) || tx_done);

   always @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         tx_st_r <= TX_IDLE;
         tx_sub_r <= 4'h0;
         tx_bits_r <= 4'h0;
         tx_sh_r <= 11'h7_ff;
         tx_brk_frame_r <= 1'b0;
         idle_q_r <= 1'b0;
         brk_q_r <= 1'b0;
         txact_r <= 1'b0;
         tx_buffer_empty_flag_r <= 1'b1;
         tc_r <= 1'b1;
         tx_buffer_empty_flag_seen_r <= 1'b0;
      end else begin
         if (tick16)
            tx_sub_r <= tx_sub_r + 4'h1;
         // Off-then-on of transmit_on queues idle; on from a dead state queues preamble
         if (c2_wr && c2_txon_new && !txon_r) begin
            idle_q_r <= 1'b1;
            txact_r <= 1'b1;
            tc_r <= 1'b0;
         end
         if (c2_wr && !c2_brk_new && brk_r) begin
            brk_q_r <= 1'b1;
            tc_r <= 1'b0;
         end
         if (stat_rd && tx_buffer_empty_flag_r)
            tx_buffer_empty_flag_seen_r <= 1'b1;
         if (data_wr && tx_buffer_empty_flag_seen_r) begin
            tx_buffer_empty_flag_r <= 1'b0;
            tx_buffer_empty_flag_seen_r <= 1'b0;
            tc_r <= 1'b0;
         end
         case (tx_st_r)
            TX_IDLE, TX_SHIFT: begin
               if (tx_st_r == TX_SHIFT && tx_bit_tick) begin
                  // LSB first, each level held sixteen sub-ticks
                  tx_sh_r <= {!tx_brk_frame_r, tx_sh_r[10:1]};
                  tx_bits_r <= tx_bits_r - 4'h1;
               end
               // Reload at the last bit edge itself, so queued frames leave no idle gap
               if (tx_slot) begin
                  tx_st_r <= TX_SHIFT;
                  if (idle_q_r) begin
                     idle_q_r <= 1'b0;
                     tx_sh_r <= 11'h7_ff;
                     tx_brk_frame_r <= 1'b0;
                     tx_bits_r <= frame_len(nine_r, 1'b0, lbrk_r);
                  end else if (brk_q_r) begin
                     // a break bit still set re-queues the next break
                     brk_q_r <= brk_r;
                     tx_sh_r <= 11'h0_00;
                     tx_brk_frame_r <= 1'b1;
                     tx_bits_r <= frame_len(nine_r, 1'b1, lbrk_r);
                  end else if (!tx_buffer_empty_flag_r) begin
                     tx_buffer_empty_flag_r <= 1'b1;
                     tx_brk_frame_r <= 1'b0;
                     tx_sh_r <= nine_r ? {1'b1, t8_r, txbuf_r, 1'b0}
                                       : {2'b11, txbuf_r, 1'b0};
                     tx_bits_r <= frame_len(nine_r, 1'b0, lbrk_r);
                  end else begin
                     tx_st_r <= TX_IDLE;
                     tx_sh_r <= 11'h7_ff;
                     if (tx_done)
                        tc_r <= 1'b1;
                     if (!txon_r)
                        txact_r <= 1'b0;
                  end
               end
            end
            default: tx_st_r <= TX_IDLE;
         endcase
      end
   end

   // Pin stage: idles high, polarity applied last, enable low while driven
   always @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         txd_out <= 1'b1;
         txd_oe_n_out <= 1'b1;
      end else begin
         txd_out <= tx_sh_r[0] ^ tx_polarity_invert_r;
         txd_oe_n_out <= !(txact_r || txon_r)
                         || (tx_done && !txon_r && tx_buffer_empty_flag_r && !idle_q_r && !brk_q_r);
      end
   end

   // Receiver
   reg [1:0] rx_st_r;
   reg [3:0] rx_sub_r;
   reg [3:0] rx_bits_r;
   reg [9:0] rx_sh_r;
   reg [2:0] rx_vote_r;
   reg rx_prev_r;
   wire rx_in = rxd_in ^ rx_polarity_invert_r;
   wire rx_fall = rx_prev_r && !rx_in;
   wire rx_maj = (rx_vote_r[0] & rx_vote_r[1]) | (rx_vote_r[1] & rx_vote_r[2])
                 | (rx_vote_r[0] & rx_vote_r[2]);

   always @(posedge sys_clk_in) begin
      if (!rstn_in || !rxon_r) begin
         rx_st_r <= RX_IDLE;
         rx_sub_r <= 4'h0;
         rx_bits_r <= 4'h0;
         rx_sh_r <= 10'h0_00;
         rx_vote_r <= 3'h7;
         rx_prev_r <= 1'b1;
      end else if (tick16) begin
         rx_prev_r <= rx_in;
         rx_sub_r <= rx_sub_r + 4'h1;
         if (rx_sub_r == `SCT_RT_S1)
            rx_vote_r[0] <= rx_in;
         if (rx_sub_r == `SCT_RT_S2)
            rx_vote_r[1] <= rx_in;
         if (rx_sub_r == `SCT_RT_S3)
            rx_vote_r[2] <= rx_in;
         case (rx_st_r)
            RX_IDLE: begin
               if (rx_fall) begin
                  rx_sub_r <= 4'h1;
                  rx_st_r <= RX_START;
               end
            end
            RX_START: begin
               // Glitch rejection: a start bit high at mid-bit is abandoned
               if (rx_sub_r == `SCT_RT_START_CHK && rx_in)
                  rx_st_r <= RX_IDLE;
               else if (rx_sub_r == `SCT_RT_LAST) begin
                  rx_bits_r <= frame_len(nine_r, 1'b0, 1'b0) - 4'h1;
                  rx_st_r <= RX_DATA;
               end
            end
            RX_DATA: begin
               if (rx_fall)
                  rx_sub_r <= 4'h1;
               if (rx_sub_r == `SCT_RT_LAST) begin
                  rx_sh_r <= {rx_maj, rx_sh_r[9:1]};
                  rx_bits_r <= rx_bits_r - 4'h1;
                  if (rx_bits_r == 4'h1)
                     rx_st_r <= RX_IDLE;
               end
            end
            default: rx_st_r <= RX_IDLE;
         endcase
      end
   end

   wire rx_done = rxon_r && tick16 && (rx_st_r == RX_DATA) && (rx_sub_r == `SCT_RT_LAST)
                  && (rx_bits_r == 4'h1);
   // Final shift brings the stop bit in at the top
   wire [9:0] rx_frame = {rx_maj, rx_sh_r[9:1]};

   // Receive buffer and its flags; a set always beats the clearing access
   always @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         rxbuf_r <= `SCT_BYTE_RST;
         r8_r <= 1'b0;
         rx_buffer_full_flag_r <= 1'b0;
         or_r <= 1'b0;
         fe_r <= 1'b0;
         rx_buffer_full_flag_seen_r <= 1'b0;
      end else begin
         if (stat_rd && rx_buffer_full_flag_r)
            rx_buffer_full_flag_seen_r <= 1'b1;
         if (data_rd && rx_buffer_full_flag_seen_r) begin
            rx_buffer_full_flag_r <= 1'b0;
            or_r <= 1'b0;
            fe_r <= 1'b0;
            rx_buffer_full_flag_seen_r <= 1'b0;
         end
         if (rx_done) begin
            if (rx_buffer_full_flag_r && !(data_rd && rx_buffer_full_flag_seen_r)) begin
               or_r <= 1'b1;
            end else begin
               rx_buffer_full_flag_r <= 1'b1;
               rx_buffer_full_flag_seen_r <= 1'b0;
               fe_r <= !rx_frame[9];
               if (nine_r) begin
                  rxbuf_r <= rx_frame[7:0];
                  r8_r <= rx_frame[8];
               end else
                  rxbuf_r <= rx_frame[8:1];
            end
         end
      end
   end

   // Register writes
   always @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         baud_r <= `SCT_BAUD_RST;
         nine_r <= 1'b0;
         lbrk_r <= 1'b0;
         rxon_r <= 1'b0;
         txon_r <= 1'b0;
         brk_r <= 1'b0;
         tx_polarity_invert_r <= 1'b0;
         rx_polarity_invert_r <= 1'b0;
         t8_r <= 1'b0;
         txbuf_r <= `SCT_BYTE_RST;
      end else if (wr_in) begin
         case (addr_in)
            `SCT_REG_BAUD: baud_r <= {5'h0_0, wdata_in};
            `SCT_REG_CTRL_ONE: begin
               nine_r <= wdata_in[`SCT_C1_NINE];
               lbrk_r <= wdata_in[`SCT_C1_LBRK];
            end
            `SCT_REG_CTRL_TWO: begin
               rxon_r <= wdata_in[`SCT_C2_RXON];
               txon_r <= wdata_in[`SCT_C2_TXON];
               brk_r <= wdata_in[`SCT_C2_BRK];
            end
            `SCT_REG_CTRL_THREE: begin
               tx_polarity_invert_r <= wdata_in[`SCT_C3_TX_POLARITY_INVERT];
               rx_polarity_invert_r <= wdata_in[`SCT_C3_RX_POLARITY_INVERT];
            end
            `SCT_REG_DATA: txbuf_r <= wdata_in;
            `SCT_REG_NINTH: t8_r <= wdata_in[`SCT_N_T8];
            default: ;
         endcase
      end
   end

   // Read data one cycle after the strobe, zero otherwise
   always @(posedge sys_clk_in) begin
      if (!rstn_in)
         rdata_out <= `SCT_BYTE_RST;
      else if (rd_in) begin
         case (addr_in)
            `SCT_REG_BAUD: rdata_out <= baud_r[7:0];
            `SCT_REG_CTRL_ONE: rdata_out <= {6'h00, lbrk_r, nine_r};
            `SCT_REG_CTRL_TWO: rdata_out <= {4'h0, txon_r, rxon_r, 1'b0, brk_r};
            `SCT_REG_STAT_ONE:
               rdata_out <= {tx_buffer_empty_flag_r, tc_r, rx_buffer_full_flag_r, 1'b0, or_r, 1'b0, fe_r, 1'b0};
            `SCT_REG_CTRL_THREE: rdata_out <= {2'b00, rx_polarity_invert_r, tx_polarity_invert_r, 4'h0};
            `SCT_REG_DATA: rdata_out <= rxbuf_r;
            `SCT_REG_NINTH: rdata_out <= {r8_r, t8_r, 6'h00};
            default: rdata_out <= `SCT_BYTE_RST;
         endcase
      end else
         rdata_out <= `SCT_BYTE_RST;
   end
endmodule // sct_core

/* test/sct_core_assertions.sv */
module sct_core_assertions (
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic [2:0] addr_in,
   input wire logic rd_in,
   input wire logic [7:0] rdata_out,
   input wire logic txd_out,
   input wire logic txd_oe_n_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rstn_in);
   sequence s_edge;
      $changed(txd_out);
   endsequence
   sequence s_hold;
      $stable(txd_out) [*8];
   endsequence
   a_idle_reset:
      assert property ($rose(rstn_in) |-> txd_out && txd_oe_n_out && rdata_out == 8'h00)
      else $error("outputs not idle after reset");
   a_bit_hold:
      assert property (s_edge |=> s_hold) else $error("tx level shorter than a bit");
   a_preamble_high:
      assert property ($fell(txd_oe_n_out) |-> txd_out [*8]) else $error("preamble not idle");
   a_released_idle:
      assert property (txd_oe_n_out |-> txd_out) else $error("released line not high");
   a_keep_frame:
      assert property ($fell(txd_out) && !txd_oe_n_out |-> !txd_oe_n_out [*8])
      else $error("pin released inside a frame");
   a_hold_char:
      assert property (!txd_oe_n_out && !txd_out |=> !txd_oe_n_out)
      else $error("pin released while low");
   a_rdata_quiet:
      assert property (!$past(rd_in) |-> rdata_out == 8'h00) else $error("data without read");
   a_unmapped_zero:
      assert property (rd_in && addr_in == 3'h7 |=> rdata_out == 8'h00)
      else $error("unmapped read not zero");
endmodule // sct_core_assertions

bind sct_core sct_core_assertions u_sct_chk (
   .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .txd_out(txd_out), .txd_oe_n_out(txd_oe_n_out));

/* test/sct_remote.sv */
module sct_remote (
   input wire logic clk_in,
   input wire logic line_in,
   output logic line_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Stop bit in bit 8; a break shows up with it low
   logic [8:0] got_q[$];
   initial line_out = 1'b1;
   // Samples mid-bit at a fixed 16 cycles a bit, so only valid with divisor 1
   initial begin : watch
      logic [8:0] f;
      forever begin
         @(negedge line_in);
         repeat (8) @(posedge clk_in);
         for (int i = 0; i < 9; i++) begin
            repeat (16) @(posedge clk_in);
            f[i] = line_in;
         end
         got_q.push_back(f);
      end
   end
   task automatic send(input logic [7:0] d, input int bt);
      logic [9:0] f;
      f = {1'b1, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         line_out <= f[i];
         repeat (bt) @(posedge clk_in);
      end
   endtask
endmodule // sct_remote

/* test/sct_core_test.sv */
`include "sct_map.vh"
module sct_core_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_in;
   logic rstn_in;
   logic [2:0] addr_in;
   logic [7:0] wdata_in;
   logic wr_in;
   logic rd_in;
   logic rxd;
   logic [7:0] rdata;
   logic txd;
   logic txd_oe_n;
   logic [7:0] s;
   int fail_count = 0;
   int checks_done = 0;
   int cycles = 0;
   sct_core dut (
      .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rxd_in(rxd), .rdata_out(rdata), .txd_out(txd),
      .txd_oe_n_out(txd_oe_n));
   sct_remote far (.clk_in(sys_clk_in), .line_in(txd), .line_out(rxd));
   initial begin
      sys_clk_in = 1'b0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // The whole run needs about 2800 cycles
   always @(posedge sys_clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         $display("timeout");
         complete_run();
      end
   end
   task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge sys_clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a);
      @(posedge sys_clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge sys_clk_in);
      rd_in <= 1'b0;
      #1 s = rdata;
   endtask
   task automatic poll_tx_buffer_empty_flag;
      int n;
      n = 0;
      do begin
         rd(`SCT_REG_STAT_ONE);
         n++;
      end while (s[7] !== 1'b1 && n < 300);
      chk("tx_buffer_empty_flag set", s[7], 1'b1);
   endtask
   task automatic t_regs;
      rd(`SCT_REG_DATA);
      chk("data reset", s, 8'h00);
      rd(3'h7);
      chk("unmapped", s, 8'h00);
      wr(`SCT_REG_BAUD, 8'h01);
      $display("registers done");
   endtask
   task automatic t_inv;
      wr(`SCT_REG_CTRL_TWO, 8'h08);
      repeat (20) @(posedge sys_clk_in);
      chk("driven", txd_oe_n, 1'b0);
      wr(`SCT_REG_CTRL_THREE, 8'h10);
      repeat (12) @(posedge sys_clk_in);
      chk("inverted idle", txd, 1'b0);
      wr(`SCT_REG_CTRL_THREE, 8'h00);
      repeat (12) @(posedge sys_clk_in);
      chk("plain idle", txd, 1'b1);
      wr(`SCT_REG_CTRL_TWO, 8'h00);
      repeat (200) @(posedge sys_clk_in);
      chk("released", txd_oe_n, 1'b1);
      $display("invert done");
   endtask
   task automatic t_tx;
      int n;
      far.got_q.delete();
      wr(`SCT_REG_CTRL_TWO, 8'h08);
      for (int i = 0; i < 2; i++) begin
         poll_tx_buffer_empty_flag();
         wr(`SCT_REG_DATA, 8'h3c ^ {8{i[0]}});
         rd(`SCT_REG_STAT_ONE);
         chk("tx_buffer_empty_flag cleared", s[7], 1'b0);
      end
      poll_tx_buffer_empty_flag();
      wr(`SCT_REG_CTRL_TWO, 8'h00);
      chk("pin kept", txd_oe_n, 1'b0);
      n = 0;
      while (far.got_q.size() < 2 && n < 1000) begin
         @(posedge sys_clk_in);
         n++;
      end
      for (int i = 0; i < 2; i++) chk("frame", far.got_q[i], {1'b1, 8'h3c ^ {8{i[0]}}});
      repeat (20) @(posedge sys_clk_in);
      rd(`SCT_REG_STAT_ONE);
      chk("tx complete", s[7:6], 2'b11);
      chk("released", txd_oe_n, 1'b1);
      $display("transmit done");
   endtask
   task automatic t_break;
      int len[4] = '{10, 11, 13, 14};
      int n;
      wr(`SCT_REG_CTRL_TWO, 8'h08);
      for (int m = 0; m < 5; m++) begin
         wr(`SCT_REG_CTRL_ONE, m == 4 ? 8'h00 : 8'(m));
         // Baud halted so the break bit is surely set again when the break loads
         if (m == 4) wr(`SCT_REG_BAUD, 8'h00);
         wr(`SCT_REG_CTRL_TWO, 8'h09);
         wr(`SCT_REG_CTRL_TWO, 8'h08);
         if (m == 4) begin
            wr(`SCT_REG_CTRL_TWO, 8'h09);
            wr(`SCT_REG_BAUD, 8'h01);
         end
         n = 0;
         while (txd !== 1'b0 && n < 600) begin
            @(posedge sys_clk_in);
            n++;
         end
         n = 0;
         // Held bit dropped inside the first break, so exactly one extra follows
         if (m == 4) begin
            repeat (98) @(posedge sys_clk_in);
            wr(`SCT_REG_CTRL_TWO, 8'h08);
            n = 100;
         end
         while (txd === 1'b0 && n < 600) begin
            @(posedge sys_clk_in);
            n++;
         end
         chk("break bits", 9'((n + 8) / 16), m == 4 ? 9'h14 : 9'(len[m]));
      end
      wr(`SCT_REG_CTRL_TWO, 8'h00);
      repeat (40) @(posedge sys_clk_in);
      $display("break done");
   endtask
   task automatic t_rx;
      wr(`SCT_REG_CTRL_TWO, 8'h04);
      far.send(8'h5a, 17);
      repeat (8) @(posedge sys_clk_in);
      wr(`SCT_REG_STAT_ONE, 8'h00);
      rd(`SCT_REG_STAT_ONE);
      chk("rx full", s & 8'h28, 8'h20);
      rd(`SCT_REG_DATA);
      chk("rx data", s, 8'h5a);
      rd(`SCT_REG_STAT_ONE);
      chk("rx cleared", s & 8'h20, 8'h00);
      far.send(8'h11, 16);
      far.send(8'h22, 16);
      repeat (8) @(posedge sys_clk_in);
      rd(`SCT_REG_STAT_ONE);
      chk("overrun", s & 8'h28, 8'h28);
      rd(`SCT_REG_DATA);
      chk("first kept", s, 8'h11);
      rd(`SCT_REG_STAT_ONE);
      chk("all cleared", s & 8'h28, 8'h00);
      wr(`SCT_REG_CTRL_TWO, 8'h00);
      far.send(8'h77, 16);
      repeat (8) @(posedge sys_clk_in);
      rd(`SCT_REG_STAT_ONE);
      chk("rx off", s & 8'h20, 8'h00);
      $display("receive done");
   endtask
   initial begin
      rstn_in = 1'b0;
      addr_in = 3'h0;
      wdata_in = 8'h00;
      wr_in = 1'b0;
      rd_in = 1'b0;
      repeat (5) @(posedge sys_clk_in);
      rstn_in <= 1'b1;
      t_regs();
      t_inv();
      t_tx();
      t_break();
      t_rx();
      complete_run();
   end
endmodule // sct_core_test
